// ### rtl/sdf_defines.svh
// Constants for the sinc3 decimation filter host
`ifndef SDF_DEFINES_SVH
`define SDF_DEFINES_SVH

// Reference clock period and wanted modulator clock period in ns
`define SDF_REF_PERIOD_NS 5
`define SDF_MCLK_PERIOD_NS 60
// Reference cycles per modulator clock half period, rounded up
`define SDF_MCLK_HALF_CYC ((`SDF_MCLK_PERIOD_NS / 2 + `SDF_REF_PERIOD_NS - 1) / `SDF_REF_PERIOD_NS)
`define SDF_DIV_W 4

// Datapath widths and output slice
`define SDF_ACC_W 24
`define SDF_WORD_W 16
`define SDF_WORD_LSB 8
`define SDF_CNT_W 8
`define SDF_CNT_MSB 7
`define SDF_STAGES 3
// Counter value just before the word clock rises
`define SDF_CNT_PRE_WORD 8'h7F

// Output buffer depth
`define SDF_FIFO_DEPTH 8

`endif

// ### rtl/sdf_pkg.sv
// Types shared by the sinc3 decimation filter host
package sdf_pkg;

  // Level of the generated modulator sample clock
  typedef enum logic {
    SDF_MCLK_LOW,
    SDF_MCLK_HIGH
  } sdf_mclk_t;

  typedef logic [23:0] sdf_acc_t;
  typedef logic [15:0] sdf_word_t;

endpackage : sdf_pkg

// ### rtl/sdf_sinc3_host.sv
// Sinc3 decimation filter host with clock generator and output FIFO
// Operation
// RULE1: Rebuild bitstream with third order sinc filter.
// RULE2: Response is cubed comb over integrator.
// RULE3: Three 24-bit integrators update on rising clock.
// RULE4: Reset clears integrators asynchronously.
// RULE5: 8-bit counter counts on falling clock.
// RULE6: Word clock is counter bit seven.
// RULE7: Three differentiators subtract previous word values.
// RULE8: Reset clears differentiators and delay registers.
// RULE9: Output word takes bits 23:8, unreset.
// RULE10: Bitstream sampled on falling clock edge.
// RULE11: Device emits one bit per sample clock.
// RULE12: Zero input alternates, full scale gives ones.
// RULE13: Input bit added unsigned, no sign extension.
`timescale 1ns/10ps
`include "sdf_defines.svh"

module sdf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic out_valid_q, out_valid_d;
  logic [WIDTH-1:0] out_data_q, out_data_d;
  logic push, pop;

  // Pointer, count and output stage next values
  always_comb begin
    push = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
    pop = (cnt_q != '0) && (!out_valid_q || out_ready_i);
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    if (push) begin
      wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      out_valid_d = 1'b1;
      out_data_d = mem[rd_ptr_q];
    end else if (out_ready_i) begin
      out_valid_d = 1'b0;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
    end
  end

  // Storage array, written on accepted pushes
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;
endmodule : sdf_fifo

module sdf_sinc3_host (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic modulator_bitstream_out_i,
  output logic modulator_sample_clock_o,
  output logic word_valid_o,
  output logic [`SDF_WORD_W-1:0] word_data_o,
  input wire logic word_ready_i,
  output logic overrun_o
);
  localparam logic [`SDF_DIV_W-1:0] HALF_LAST = `SDF_DIV_W'(`SDF_MCLK_HALF_CYC - 1);

  sdf_pkg::sdf_mclk_t mclk_st_q, mclk_st_d;
  logic [`SDF_DIV_W-1:0] div_cnt_q, div_cnt_d;
  logic mclk_q, mclk_d, rise_en, fall_en;
  logic sync1_q, sync2_q, bit_q, bit_d;
  sdf_pkg::sdf_acc_t int_q [`SDF_STAGES];
  sdf_pkg::sdf_acc_t int_d [`SDF_STAGES];
  sdf_pkg::sdf_acc_t diff_q [`SDF_STAGES];
  sdf_pkg::sdf_acc_t diff_d [`SDF_STAGES];
  sdf_pkg::sdf_acc_t dly_q [`SDF_STAGES];
  sdf_pkg::sdf_acc_t dly_d [`SDF_STAGES];
  logic [`SDF_CNT_W-1:0] dec_cnt_q, dec_cnt_d;
  logic word_tick;
  sdf_pkg::sdf_word_t word_q, word_d;
  logic pend_q, pend_d, ovr_q, ovr_d, fifo_rdy;
  logic fifo_valid;
  logic [`SDF_WORD_W-1:0] fifo_data;

  // Sample clock divider with rise and fall enables
  // RULE11: one bit per clock
  always_comb begin
    div_cnt_d = div_cnt_q + 1'b1;
    mclk_st_d = mclk_st_q;
    rise_en = 1'b0;
    fall_en = 1'b0;
    if (div_cnt_q == HALF_LAST) begin
      div_cnt_d = '0;
      unique case (mclk_st_q)
        sdf_pkg::SDF_MCLK_LOW: begin
          mclk_st_d = sdf_pkg::SDF_MCLK_HIGH;
          rise_en = 1'b1;
        end
        sdf_pkg::SDF_MCLK_HIGH: begin
          mclk_st_d = sdf_pkg::SDF_MCLK_LOW;
          fall_en = 1'b1;
        end
      endcase
    end
    mclk_d = (mclk_st_d == sdf_pkg::SDF_MCLK_HIGH);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_q <= '0;
      mclk_st_q <= sdf_pkg::SDF_MCLK_LOW;
      mclk_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      mclk_st_q <= mclk_st_d;
      mclk_q <= mclk_d;
    end
  end

  // Bitstream synchroniser and falling edge sample
  // RULE10: falling edge sample
  always_comb begin
    bit_d = fall_en ? sync2_q : bit_q;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      sync1_q <= modulator_bitstream_out_i;
      sync2_q <= sync1_q;
      bit_q <= bit_d;
    end
  end

  // Integrator cascade at the modulator rate
  // RULE1: sinc3 integrator half
  always_comb begin
    for (int k = 0; k < `SDF_STAGES; k++) begin
      int_d[k] = int_q[k];
    end
    if (rise_en) begin
      // RULE13: unsigned input bit
      int_d[0] = int_q[0] + {{(`SDF_ACC_W-1){1'b0}}, bit_q};
      // RULE3: cascaded integrator update
      for (int k = 1; k < `SDF_STAGES; k++) begin
        int_d[k] = int_q[k] + int_q[k-1];
      end
    end
  end

  // RULE4: async integrator clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < `SDF_STAGES; k++) begin
        int_q[k] <= '0;
      end
    end else begin
      int_q <= int_d;
    end
  end

  // Decimation counter on falling modulator edges
  // RULE5: falling edge count
  always_comb begin
    dec_cnt_d = fall_en ? dec_cnt_q + 1'b1 : dec_cnt_q;
    // RULE6: counter msb rising
    word_tick = fall_en && (dec_cnt_q == `SDF_CNT_PRE_WORD);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_cnt_q <= '0;
    end else begin
      dec_cnt_q <= dec_cnt_d;
    end
  end

  // Differentiator cascade at the word rate
  // RULE2: comb stages complete response
  always_comb begin
    for (int k = 0; k < `SDF_STAGES; k++) begin
      diff_d[k] = diff_q[k];
      dly_d[k] = dly_q[k];
    end
    if (word_tick) begin
      // RULE7: subtract previous word value
      diff_d[0] = int_q[`SDF_STAGES-1] - dly_q[0];
      dly_d[0] = int_q[`SDF_STAGES-1];
      for (int k = 1; k < `SDF_STAGES; k++) begin
        diff_d[k] = diff_q[k-1] - dly_q[k];
        dly_d[k] = diff_q[k-1];
      end
    end
  end

  // RULE8: async differentiator clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int k = 0; k < `SDF_STAGES; k++) begin
        diff_q[k] <= '0;
        dly_q[k] <= '0;
      end
    end else begin
      diff_q <= diff_d;
      dly_q <= dly_d;
    end
  end

  // Output word register, deliberately without reset
  // RULE9: top sixteen bits captured
  always_comb begin
    word_d = word_tick ? diff_q[`SDF_STAGES-1][`SDF_ACC_W-1:`SDF_WORD_LSB] : word_q;
  end

  always_ff @(posedge ref_clk_i) begin
    word_q <= word_d;
  end

  // Pending word handshake into the FIFO and sticky overrun
  always_comb begin
    pend_d = pend_q;
    if (pend_q && fifo_rdy) begin
      pend_d = 1'b0;
    end
    if (word_tick) begin
      pend_d = 1'b1;
    end
    ovr_d = ovr_q || (word_tick && pend_q && !fifo_rdy);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      ovr_q <= ovr_d;
    end
  end

  sdf_fifo #(
    .WIDTH(`SDF_WORD_W),
    .DEPTH(`SDF_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(pend_q),
    .in_data_i(word_q),
    .in_ready_o(fifo_rdy),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(word_ready_i)
  );

  // Outputs straight from flip-flops
  assign modulator_sample_clock_o = mclk_q;
  assign word_valid_o = fifo_valid;
  assign word_data_o = fifo_data;
  assign overrun_o = ovr_q;

  // Checks on the filter datapath
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_MCLK_HIGH_TIME: assert property (rise_en |=> mclk_q [*6] ##1 !mclk_q) // RULE11
    else $error("sample clock high time wrong");
  AST_SAMPLE_FALL: assert property (fall_en |=> bit_q == $past(sync2_q)) // RULE10
    else $error("bit not sampled on falling edge");
  AST_INT_FIRST: assert property (rise_en |=> int_q[0] == $past(int_q[0]) + $past(bit_q)) // RULE13
    else $error("first integrator wrong");
  AST_INT_CHAIN: assert property (rise_en |=> int_q[2] == $past(int_q[2]) + $past(int_q[1])) // RULE3
    else $error("integrator chain wrong");
  AST_INT_HOLD: assert property (!rise_en |=> $stable(int_q[1])) // RULE3
    else $error("integrator moved off rising edge");
  AST_CNT_STEP: assert property (fall_en |=> dec_cnt_q == $past(dec_cnt_q) + 8'h01) // RULE5
    else $error("decimation counter step wrong");
  AST_CNT_HOLD: assert property (!fall_en |=> $stable(dec_cnt_q)) // RULE5
    else $error("decimation counter moved");
  AST_TICK_MSB: assert property (word_tick |=> $rose(dec_cnt_q[`SDF_CNT_MSB])) // RULE6
    else $error("word tick not at msb rise");
  AST_DIFF_FIRST: assert property (word_tick |=> diff_q[0] == $past(int_q[2]) - $past(dly_q[0])) // RULE7
    else $error("first differentiator wrong");
  AST_DIFF_HOLD: assert property (!word_tick |=> $stable(diff_q[2]) && $stable(dly_q[0])) // RULE7
    else $error("differentiator moved off word tick");
  AST_WORD_SLICE: assert property (word_tick |=> word_q == $past(diff_q[2][23:8])) // RULE9
    else $error("output word slice wrong");

  COV_WORD: cover property (word_tick ##1 pend_q);
  COV_BIT_HIGH: cover property (fall_en && sync2_q);
  COV_STALL: cover property (word_valid_o && !word_ready_i);
  COV_OVERRUN: cover property ($rose(ovr_q));
endmodule : sdf_sinc3_host

// ### verif/sdf_mod_model.sv
// Behavioural isolated modulator model playing a repeating 4-bit pattern
`timescale 1ns/10ps

module sdf_mod_model (
  input wire logic modulator_sample_clock_i,
  input wire logic [3:0] pattern_i,
  output logic modulator_bitstream_out_o
);
  logic [1:0] slot_q = 2'h0;

  always @(posedge modulator_sample_clock_i) begin
    slot_q <= slot_q + 2'h1;
  end

  assign modulator_bitstream_out_o = pattern_i[slot_q];
endmodule : sdf_mod_model

// ### verif/tb_top.sv
// Self-checking bench for the sinc3 decimation filter host
`timescale 1ns/10ps

module tb_top;
  logic ref_clk_i;
  logic rst_i;
  logic bit_w;
  logic mclk_w;
  logic word_valid_o;
  logic word_ready_i;
  logic overrun_o;
  logic [15:0] word_data_o;
  logic [3:0] pattern;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  sdf_sinc3_host uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .modulator_bitstream_out_i(bit_w),
    .modulator_sample_clock_o(mclk_w), .word_valid_o(word_valid_o),
    .word_data_o(word_data_o), .word_ready_i(word_ready_i), .overrun_o(overrun_o)
  );

  sdf_mod_model model (
    .modulator_sample_clock_i(mclk_w), .pattern_i(pattern), .modulator_bitstream_out_o(bit_w)
  );

  // Reference clock, 5 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // Cycle counter and hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Wait for a word at a falling edge, let the next rising edge take it
  task automatic get_word(output logic [15:0] w);
    int n;
    n = 0;
    while (word_valid_o !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(n < 4000, 1'b1);
    w = word_data_o;
    @(negedge ref_clk_i);
  endtask : get_word

  // Count falling edges while the sample clock holds a level
  task automatic level_len(input logic lvl, output int n);
    n = 0;
    while (mclk_w === lvl && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask : level_len

  // Reset values, then sample clock shape
  task automatic test_reset_clock();
    int n;
    check({mclk_w, word_valid_o, overrun_o}, 3'h0);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    level_len(1'b0, n);
    level_len(1'b1, n);
    check(n, 6);
    level_len(1'b0, n);
    check(n, 6);
  endtask : test_reset_clock

  // Stall the consumer until the buffer refuses, then drain it
  task automatic test_stall();
    logic [15:0] held;
    logic [15:0] w;
    int n;
    repeat (12 * 3072) @(negedge ref_clk_i);
    check({word_valid_o, overrun_o}, 2'h3);
    held = word_data_o;
    repeat (40) @(negedge ref_clk_i);
    check(word_data_o, held);
    word_ready_i = 1'b1;
    n = 0;
    while (word_valid_o === 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    // Output register, eight stored words and the pending one
    check(n, 10);
    get_word(w);
    get_word(w);
    check(w, 16'h8000);
  endtask : test_stall

  // Pattern densities through the settled filter, and word spacing
  task automatic test_patterns();
    logic [3:0] pats [2] = '{4'h7, 4'hF};
    logic [15:0] exps [2] = '{16'hC000, 16'h0000};
    logic [15:0] w;
    int t1;
    for (int i = 0; i < 2; i++) begin
      pattern = pats[i];
      repeat (5) get_word(w);
      t1 = cyc;
      get_word(w);
      check(cyc - t1, 3072);
      get_word(w);
      check(w, exps[i]);
    end
  endtask : test_patterns

  // Reset in mid-run clears at once, then the cleared combs give three empty words
  task automatic test_midrun_reset();
    logic [15:0] w;
    rst_i = 1'b1;
    #1;
    check({mclk_w, word_valid_o, overrun_o}, 3'h0);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    // stale mid-scale word must not return
    for (int i = 0; i < 3; i++) begin
      get_word(w);
      check(w, 16'h0000);
    end
  endtask : test_midrun_reset

  // Main sequence
  initial begin
    rst_i = 1'b1;
    word_ready_i = 1'b0;
    pattern = 4'h5;
    repeat (5) @(negedge ref_clk_i);
    test_reset_clock();
    test_stall();
    test_midrun_reset();
    test_patterns();
    summarize();
  end
endmodule : tb_top
